// >>> rtl/lldc_pkg.sv
// Package: constants and types for the DRAM command decoder
package lldc_pkg;
    // Widths
    localparam int ADDR_W      = 21;
    localparam int BANK_W      = 3;
    localparam int MODE_W      = 18;
    localparam int NUM_BANKS   = 8;
    localparam int ROW_W       = 13;
    localparam int LAT_W       = 4;

    // Reset values
    localparam logic [17:0] MODE_RESET    = 18'h00000;
    localparam logic [12:0] REF_ROW_RESET = 13'h0000;

    // Mode register field positions: configuration M0..M2, burst length M3..M4
    localparam int MODE_CFG_LSB = 0;
    localparam int MODE_BL_LSB  = 3;

    // Read latency in cycles per configuration code (codes 1..5, others fall back)
    localparam logic [3:0] RL_CFG1 = 4'h4;
    localparam logic [3:0] RL_CFG2 = 4'h6;
    localparam logic [3:0] RL_CFG3 = 4'h8;
    localparam logic [3:0] RL_CFG4 = 4'h3;
    localparam logic [3:0] RL_CFG5 = 4'h5;
    localparam logic [3:0] WL_EXTRA = 4'h1;

    // Burst length codes and beat counts
    localparam logic [1:0] BL2_CODE  = 2'h0;
    localparam logic [1:0] BL4_CODE  = 2'h1;
    localparam logic [1:0] BL8_CODE  = 2'h2;
    localparam logic [3:0] BEATS_BL2 = 4'h2;
    localparam logic [3:0] BEATS_BL4 = 4'h4;
    localparam logic [3:0] BEATS_BL8 = 4'h8;

    // Refresh busy time in cycles per bank
    localparam logic [3:0] REF_BUSY_CYC = 4'h4;

    // Decoded command, one-hot
    typedef enum logic [4:0] {
        CMD_IDLE  = 5'b00001,
        CMD_MODE  = 5'b00010,
        CMD_READ  = 5'b00100,
        CMD_WRITE = 5'b01000,
        CMD_UPKP  = 5'b10000
    } lldc_cmd_type;
endpackage

// >>> rtl/lldc_bank_timer.sv
// One refresh busy timer per bank
`timescale 1ns/10ps
module lldc_bank_timer #(
    parameter int NUM_BANKS = 8
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    input  wire logic [NUM_BANKS-1:0] start,
    output logic      [NUM_BANKS-1:0] busy
);
    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : gen_bank
            logic [3:0] cnt_reg;
            // A refresh keeps its bank busy for a fixed count, idle cycles do not cut it short
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    cnt_reg <= 4'h0;
                end else if (clk_en) begin
                    if (start[g]) begin
                        cnt_reg <= lldc_pkg::REF_BUSY_CYC;
                    end else if (cnt_reg != 4'h0) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
            end
            assign busy[g] = (cnt_reg != 4'h0);
        end
    endgenerate
endmodule

// >>> rtl/lldc_decode.sv
// Command decoder of a low-latency eight-bank DRAM
//
// What this block does, and what the controller driving it does
// [R01] Strobes, bank and address captured each rising edge; one command decoded per edge. Code captures only while clk_en is high.
// [R02] Controller issues only listed encodings and sequences; others are reserved.
// [R03] Device select high means internal no-op; nothing accepted.
// [R04] Idle cycles leave running reads, writes, refreshes and mode loads untouched.
// [R05] Write/refresh strobes: LL mode load, HH read, LH write, HL refresh.
// [R06] Mode load stores address bits 0..17 into the mode register.
// [R07] Controller issues mode load only with all banks idle.
// [R08] Read starts a burst at selected bank and address.
// [R09] Write starts a burst at selected bank and address from the data lines.
// [R10] Mask low with a data beat stores that beat.
// [R11] Mask high with a data beat discards it; stored word unchanged.
// [R12] Refresh uses selected bank and internal row counter; address ignored.
// [R13] Refresh does not repeat; controller issues each one.
// [R14] Read/write address up to bit 20; used width follows burst length.
// [R15] Controller may group eight refreshes every 3.90 us.
// [R16] Controller should drive idle during idle and wait cycles.
// [R17] Controller waits the mode load settle time after a mode load.
// [R18] Write data expected one clock after read data would return.
// [R19] Illegal strobe combinations act as idle; nothing started.
`timescale 1ns/10ps
module lldc_decode #(
    parameter int ADDR_W    = lldc_pkg::ADDR_W,
    parameter int BANK_W    = lldc_pkg::BANK_W,
    parameter int NUM_BANKS = lldc_pkg::NUM_BANKS,
    parameter int ROW_W     = lldc_pkg::ROW_W
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    input  wire logic                 device_select_n,
    input  wire logic                 write_strobe_n,
    input  wire logic                 row_upkeep_n,
    input  wire logic [ADDR_W-1:0]    addr,
    input  wire logic [BANK_W-1:0]    bank_select,
    input  wire logic                 write_mask,
    output logic      [17:0]          mode_reg,
    output logic                      rd_start,
    output logic                      wr_start,
    output logic      [BANK_W-1:0]    op_bank,
    output logic      [ADDR_W-1:0]    op_addr,
    output logic                      rd_beat,
    output logic                      wr_beat,
    output logic                      wr_beat_store,
    output logic                      ref_start,
    output logic      [ROW_W-1:0]     ref_row,
    output logic      [NUM_BANKS-1:0] bank_ref_busy,
    output logic                      burst_active
);
    // Captured inputs
    logic                 sel_n_reg;
    logic                 we_n_reg;
    logic                 ref_n_reg;
    logic [ADDR_W-1:0]    addr_reg;
    logic [BANK_W-1:0]    bank_reg;
    lldc_pkg::lldc_cmd_type cmd_next;

    // Latency pipelines, one bit per cycle of delay
    logic [15:0]          rd_pipe_reg;
    logic [15:0]          wr_pipe_reg;
    logic [3:0]           rd_left_reg;
    logic [3:0]           wr_left_reg;
    logic [3:0]           rl_cyc;
    logic [3:0]           wl_cyc;
    logic [3:0]           beats;
    logic [ADDR_W-1:0]    addr_mask;
    logic [ROW_W-1:0]     row_cnt_reg;
    logic [NUM_BANKS-1:0] ref_kick;
    logic [NUM_BANKS-1:0] busy_w;

    // Capture select, strobes, address and bank on the rising edge; frozen when the clock enable is low
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sel_n_reg <= 1'b1;
            we_n_reg  <= 1'b1;
            ref_n_reg <= 1'b1;
            addr_reg  <= '0;
            bank_reg  <= '0;
        end else if (clk_en) begin
            sel_n_reg <= device_select_n; // R01
            we_n_reg  <= write_strobe_n;
            ref_n_reg <= row_upkeep_n;
            addr_reg  <= addr;
            bank_reg  <= bank_select;
        end
    end

    // Decode one command from the captured strobes
    always_comb begin
        if (sel_n_reg) begin
            cmd_next = lldc_pkg::CMD_IDLE; // R03
        end else begin
            unique case ({we_n_reg, ref_n_reg}) // R05
                2'b00:   cmd_next = lldc_pkg::CMD_MODE;
                2'b11:   cmd_next = lldc_pkg::CMD_READ;
                2'b01:   cmd_next = lldc_pkg::CMD_WRITE;
                2'b10:   cmd_next = lldc_pkg::CMD_UPKP;
                default: cmd_next = lldc_pkg::CMD_IDLE; // R19
            endcase
        end
    end

    // Latency from configuration code; write waits one cycle longer than read
    always_comb begin
        unique case (mode_reg[lldc_pkg::MODE_CFG_LSB +: 3])
            3'h2:    rl_cyc = lldc_pkg::RL_CFG2;
            3'h3:    rl_cyc = lldc_pkg::RL_CFG3;
            3'h4:    rl_cyc = lldc_pkg::RL_CFG4;
            3'h5:    rl_cyc = lldc_pkg::RL_CFG5;
            default: rl_cyc = lldc_pkg::RL_CFG1;
        endcase
        wl_cyc = rl_cyc + lldc_pkg::WL_EXTRA; // R18
    end

    // Burst length sets beat count and the address bits that matter
    always_comb begin
        unique case (mode_reg[lldc_pkg::MODE_BL_LSB +: 2])
            lldc_pkg::BL4_CODE: begin
                beats     = lldc_pkg::BEATS_BL4;
                addr_mask = {1'b0, {(ADDR_W-1){1'b1}}}; // R14
            end
            lldc_pkg::BL8_CODE: begin
                beats     = lldc_pkg::BEATS_BL8;
                addr_mask = {2'b00, {(ADDR_W-2){1'b1}}};
            end
            default: begin
                beats     = lldc_pkg::BEATS_BL2;
                addr_mask = {ADDR_W{1'b1}};
            end
        endcase
    end

    // Mode register load; other commands leave it alone
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_reg <= lldc_pkg::MODE_RESET;
        end else if (clk_en && cmd_next == lldc_pkg::CMD_MODE) begin
            mode_reg <= addr_reg[17:0]; // R06
        end
    end

    // Start strobes and target of the accepted access
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_start  <= 1'b0;
            wr_start  <= 1'b0;
            ref_start <= 1'b0;
            op_bank   <= '0;
            op_addr   <= '0;
        end else if (clk_en) begin
            rd_start  <= (cmd_next == lldc_pkg::CMD_READ);  // R08
            wr_start  <= (cmd_next == lldc_pkg::CMD_WRITE); // R09
            ref_start <= (cmd_next == lldc_pkg::CMD_UPKP);  // R12
            // Idle keeps the last target so a running burst still sees it
            if (cmd_next == lldc_pkg::CMD_READ || cmd_next == lldc_pkg::CMD_WRITE) begin
                op_bank <= bank_reg;
                op_addr <= addr_reg & addr_mask;
            end else if (cmd_next == lldc_pkg::CMD_UPKP) begin
                op_bank <= bank_reg; // R12
            end
        end
    end

    // Internal refresh row counter, advanced once per refresh command
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            row_cnt_reg <= lldc_pkg::REF_ROW_RESET;
            ref_row     <= lldc_pkg::REF_ROW_RESET;
        end else if (clk_en && cmd_next == lldc_pkg::CMD_UPKP) begin
            ref_row     <= row_cnt_reg; // R12
            row_cnt_reg <= row_cnt_reg + ROW_W'(1);
        end
    end

    // Latency pipelines: a shifted marker reaches bit 0 when the first beat is due
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_pipe_reg <= '0;
            wr_pipe_reg <= '0;
        end else if (clk_en) begin
            rd_pipe_reg <= rd_pipe_reg >> 1;
            wr_pipe_reg <= wr_pipe_reg >> 1;
            if (cmd_next == lldc_pkg::CMD_READ) begin
                rd_pipe_reg[rl_cyc - 4'h1] <= 1'b1;
            end
            if (cmd_next == lldc_pkg::CMD_WRITE) begin
                wr_pipe_reg[wl_cyc - 4'h1] <= 1'b1; // R18
            end
        end
    end

    // Beat counters; idle commands never clear them, so bursts run to completion
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_left_reg <= 4'h0;
            wr_left_reg <= 4'h0;
        end else if (clk_en) begin
            if (rd_pipe_reg[0]) begin
                rd_left_reg <= beats - 4'h1; // R04
            end else if (rd_left_reg != 4'h0) begin
                rd_left_reg <= rd_left_reg - 4'h1;
            end
            if (wr_pipe_reg[0]) begin
                wr_left_reg <= beats - 4'h1;
            end else if (wr_left_reg != 4'h0) begin
                wr_left_reg <= wr_left_reg - 4'h1;
            end
        end
    end

    // Beat strobes; the mask is sampled with the write data of the same beat
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_beat       <= 1'b0;
            wr_beat       <= 1'b0;
            wr_beat_store <= 1'b0;
            burst_active  <= 1'b0;
        end else if (clk_en) begin
            rd_beat       <= rd_pipe_reg[0] || (rd_left_reg != 4'h0);
            wr_beat       <= wr_pipe_reg[0] || (wr_left_reg != 4'h0);
            // Low mask stores the beat, high mask drops it
            wr_beat_store <= (wr_pipe_reg[0] || (wr_left_reg != 4'h0)) && !write_mask; // R10 R11
            burst_active  <= (|rd_pipe_reg) || (|wr_pipe_reg) || (rd_left_reg != 4'h0) || (wr_left_reg != 4'h0);
        end
    end

    // Refresh kicks per bank; one-hot from the bank field
    always_comb begin
        ref_kick = '0;
        if (cmd_next == lldc_pkg::CMD_UPKP) begin
            ref_kick[bank_reg] = 1'b1;
        end
    end

    lldc_bank_timer #(
        .NUM_BANKS (NUM_BANKS)
    ) u_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .start   (ref_kick),
        .busy    (busy_w)
    );

    // Register the busy view so the output comes from a flip-flop
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bank_ref_busy <= '0;
        end else if (clk_en) begin
            bank_ref_busy <= busy_w;
        end
    end
endmodule

// >>> test/lldc_properties.sv
// Port checker for the command decoder
`timescale 1ns/10ps
module lldc_properties #(parameter int ADDR_W = 21, parameter int BANK_W = 3, parameter int NUM_BANKS = 8) (
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic              clk_en,
    input wire logic              device_select_n,
    input wire logic              write_strobe_n,
    input wire logic              row_upkeep_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [BANK_W-1:0] bank_select,
    input wire logic              write_mask,
    input wire logic [17:0]       mode_reg,
    input wire logic              rd_start,
    input wire logic              wr_start,
    input wire logic [BANK_W-1:0] op_bank,
    input wire logic              wr_beat,
    input wire logic              wr_beat_store,
    input wire logic              ref_start,
    input wire logic [NUM_BANKS-1:0] bank_ref_busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [1:0] up_reg;
    // Edges since reset; the two-edge decode pipe holds stale zeros until full
    always_ff @(posedge ref_clk) begin
        if (!rst_n) up_reg <= 2'h0;
        else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
    end
    // Decoded strobe levels at the pins
    wire sel = !device_select_n && clk_en;
    wire is_rd = sel && write_strobe_n && row_upkeep_n;
    wire is_wr = sel && !write_strobe_n && row_upkeep_n;
    wire is_rf = sel && write_strobe_n && !row_upkeep_n;
    wire is_md = sel && !write_strobe_n && !row_upkeep_n;
    wire up = up_reg == 2'h3;
    property p_rd; up |-> rd_start == $past(is_rd, 2); endproperty
    property p_wr; up |-> wr_start == $past(is_wr, 2); endproperty
    property p_rf; up |-> ref_start == $past(is_rf, 2); endproperty
    property p_md; up && $past(is_md, 2) |-> mode_reg == $past(addr[17:0], 2); endproperty
    property p_hold; up && !$past(is_md, 2) |-> $stable(mode_reg); endproperty
    property p_desel; up && $past(device_select_n, 2) |-> !(rd_start || wr_start || ref_start); endproperty
    property p_one; $onehot0({rd_start, wr_start, ref_start}); endproperty
    property p_bank; rd_start || wr_start |-> op_bank == $past(bank_select, 2); endproperty
    property p_mask; wr_beat |-> wr_beat_store == !$past(write_mask); endproperty
    // Write latency spans the configurations: one more than read latency 3..8
    property p_wlat; wr_start |-> ##[4:9] wr_beat; endproperty
    property p_busy; ref_start |=> bank_ref_busy[$past(op_bank)]; endproperty
    a_rd: assert property (p_rd) else $error("read start mismatch");
    a_wr: assert property (p_wr) else $error("write start mismatch");
    a_rf: assert property (p_rf) else $error("refresh start mismatch");
    a_md: assert property (p_md) else $error("mode value mismatch");
    a_hold: assert property (p_hold) else $error("mode changed");
    a_desel: assert property (p_desel) else $error("deselect accepted");
    a_one: assert property (p_one) else $error("two starts");
    a_bank: assert property (p_bank) else $error("bank mismatch");
    a_mask: assert property (p_mask) else $error("mask mismatch");
    a_wlat: assert property (p_wlat) else $error("no write beat");
    a_busy: assert property (p_busy) else $error("refreshed bank not busy");
    c_rd: cover property (rd_start);
    c_rf: cover property (ref_start);
    c_wr: cover property (wr_start);
    c_drop: cover property (wr_beat && !wr_beat_store);
endmodule
bind lldc_decode lldc_properties #(.ADDR_W(ADDR_W), .BANK_W(BANK_W), .NUM_BANKS(NUM_BANKS)) lldc_properties_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .device_select_n(device_select_n),
    .write_strobe_n(write_strobe_n), .row_upkeep_n(row_upkeep_n), .addr(addr),
    .bank_select(bank_select), .write_mask(write_mask), .mode_reg(mode_reg), .rd_start(rd_start),
    .wr_start(wr_start), .op_bank(op_bank), .wr_beat(wr_beat), .wr_beat_store(wr_beat_store),
    .ref_start(ref_start), .bank_ref_busy(bank_ref_busy));

// >>> test/lldc_ctrl_model.sv
// Memory controller model driving the command pins
`timescale 1ns/10ps
module lldc_ctrl_model (
    input wire logic ref_clk,
    output logic     device_select_n,
    output logic     write_strobe_n,
    output logic     row_upkeep_n,
    output logic [20:0] addr,
    output logic [2:0]  bank_select,
    output logic     write_mask
);
    // Known levels from time zero
    initial begin
        device_select_n = 1'b1;
        write_strobe_n = 1'b0;
        row_upkeep_n = 1'b1;
        addr = 21'h0;
        bank_select = 3'h0;
        write_mask = 1'b0;
    end
    // Idle cycles: deselected, other lines scrambled so stale values never look valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            device_select_n <= 1'b1;
            write_strobe_n <= ~write_strobe_n;
            row_upkeep_n <= write_strobe_n;
            addr <= ~addr;
            bank_select <= ~bank_select;
            write_mask <= ~write_mask;
        end
    endtask
    // One listed command for one cycle; callers keep mode loads to idle banks
    task automatic cmd(input logic [1:0] ws, input logic [2:0] b, input logic [20:0] a);
        @(posedge ref_clk);
        device_select_n <= 1'b0;
        {write_strobe_n, row_upkeep_n} <= ws;
        addr <= a;
        bank_select <= b;
    endtask
endmodule

// >>> test/lldc_decode_tb.sv
// Self-checking bench for the command decoder
`timescale 1ns/10ps
module lldc_decode_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic sel_n, we_n, up_n, wm, rd_s, wr_s, rf_s, rd_b, wr_b, burst;
    logic [20:0] a, op_addr;
    logic [2:0] ba, op_bank;
    logic [17:0] mode_reg;
    logic [12:0] ref_row;
    logic [12:0] row_exp = lldc_pkg::REF_ROW_RESET;
    logic [7:0] busy_v;
    int errors = 0, tests_run = 0, rd_cnt = 0, wr_cnt = 0;
    // Cycle stamps of the last start and the latency to its first beat
    int cyc = 0, rd_at = 0, wr_at = 0, rd_lat = 0, wr_lat = 0;
    logic rd_wait = 1'b0, wr_wait = 1'b0;
    // Mode load settle time in cycles; arbitrary plain default
    localparam int MODE_SETTLE = 3;
    logic [26:0] exp_q[$];
    logic [7:0] lfsr = 8'h5F;
    logic [20:0] amask;
    always #2.5 ref_clk = ~ref_clk;
    lldc_ctrl_model lldc_ctrl_model_i (.ref_clk(ref_clk), .device_select_n(sel_n), .write_strobe_n(we_n),
        .row_upkeep_n(up_n), .addr(a), .bank_select(ba), .write_mask(wm));
    lldc_decode lldc_decode_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .device_select_n(sel_n),
        .write_strobe_n(we_n), .row_upkeep_n(up_n), .addr(a), .bank_select(ba), .write_mask(wm),
        .mode_reg(mode_reg), .rd_start(rd_s), .wr_start(wr_s), .op_bank(op_bank), .op_addr(op_addr),
        .rd_beat(rd_b), .wr_beat(wr_b), .wr_beat_store(), .ref_start(rf_s), .ref_row(ref_row),
        .bank_ref_busy(busy_v), .burst_active(burst));
    function automatic logic [20:0] rnd();
        repeat (3) lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return {lfsr, lfsr[4:0], lfsr};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Note what each command must start, then send it
    task automatic do_cmd(input logic [1:0] ws, input logic [2:0] b, input logic [20:0] ad);
        if (ws == 2'b11) exp_q.push_back({3'b100, b, ad & amask});
        if (ws == 2'b01) exp_q.push_back({3'b010, b, ad & amask});
        if (ws == 2'b10) begin
            exp_q.push_back({3'b001, b, 8'h00, row_exp});
            row_exp++;
        end
        lldc_ctrl_model_i.cmd(ws, b, ad);
    endtask
    // Every start takes the oldest note; a start with no note is a fault
    always @(posedge ref_clk) begin
        cyc++;
        if (rd_b === 1'b1) rd_cnt++;
        if (wr_b === 1'b1) wr_cnt++;
        // First beat after a start gives the latency in cycles
        if (rd_b === 1'b1 && rd_wait) begin
            rd_lat = cyc - rd_at;
            rd_wait = 1'b0;
        end
        if (wr_b === 1'b1 && wr_wait) begin
            wr_lat = cyc - wr_at;
            wr_wait = 1'b0;
        end
        if (rd_s === 1'b1) begin
            rd_at = cyc;
            rd_wait = 1'b1;
        end
        if (wr_s === 1'b1) begin
            wr_at = cyc;
            wr_wait = 1'b1;
        end
        if ((rd_s | wr_s | rf_s) === 1'b1) begin
            if (exp_q.size() == 0) cmp(32'h1, 32'h0);
            else cmp({rd_s, wr_s, rf_s, op_bank, rf_s ? {8'h00, ref_row} : op_addr}, exp_q.pop_front());
        end
    end
    initial begin
        #100000;
        errors++;
        results();
    end
    initial begin
        logic [20:0] op;
        logic [3:0] rl;
        int c;
        amask = 21'h1FFFFF;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        lldc_ctrl_model_i.idle(4);
        // Each burst code, with a different latency configuration
        for (int b = 0; b < 4; b++) begin
            op = rnd();
            // Configurations 5..2 in bits 0..2; the loop index as burst code in bits 3..4
            op[4:0] = {2'(b), 3'(5 - b)};
            do_cmd(2'b00, 3'(b), op);
            lldc_ctrl_model_i.idle(MODE_SETTLE);
            cmp(mode_reg, op[17:0]);
            rl = b == 0 ? lldc_pkg::RL_CFG5 : b == 1 ? lldc_pkg::RL_CFG4 : b == 2 ? lldc_pkg::RL_CFG3 : lldc_pkg::RL_CFG2;
            amask = b == 1 ? 21'h0FFFFF : b == 2 ? 21'h07FFFF : 21'h1FFFFF;
            c = rd_cnt;
            do_cmd(2'b11, 3'(7 - b), rnd());
            lldc_ctrl_model_i.idle(20);
            cmp(rd_cnt - c, b == 1 ? 4 : b == 2 ? 8 : 2);
            cmp(rd_lat, rl);
            c = wr_cnt;
            do_cmd(2'b01, 3'(b + 2), rnd());
            lldc_ctrl_model_i.idle(20);
            cmp(wr_cnt - c, b == 1 ? 4 : b == 2 ? 8 : 2);
            cmp(wr_lat, rl + 4'h1);
        end
        // Eight refreshes back to back, one per bank
        for (int i = 0; i < 8; i++) do_cmd(2'b10, 3'(i), rnd());
        lldc_ctrl_model_i.idle(12);
        cmp(busy_v, 8'h00);
        // A read driven while the clock enable is low must start nothing
        clk_en <= 1'b0;
        lldc_ctrl_model_i.cmd(2'b11, 3'h5, rnd());
        lldc_ctrl_model_i.idle(2);
        clk_en <= 1'b1;
        lldc_ctrl_model_i.idle(6);
        cmp(exp_q.size(), 0);
        cmp(burst, 1'b0);
        cmp(mode_reg, op[17:0]);
        results();
    end
endmodule
